// *** rtl/sfi_irq_ctrl.v ***
// interrupt status, stacking, masking and line routing for one scsi function
`include "sfi_irq_defines.vh"

//
// Contract
// RULE_01 - function A requests drive line A
// RULE_02 - function B uses line B, strap selects A
// RULE_03 - only status group reachable while script runs
// RULE_04 - on-the-fly flag clears only on write one
// RULE_05 - host clears on-the-fly flag first
// RULE_06 - scsi events set scsi pending flag
// RULE_07 - dma events set dma pending flag
// RULE_08 - host reads scsi status before dma status
// RULE_09 - pin disable blocks new line assertions only
// RULE_10 - host retries status group reads
// RULE_11 - scsi status records regardless of enables
// RULE_12 - scsi status read clears bits and pending
// RULE_13 - fatal while receiving: drain fifo first
// RULE_14 - scsi status read clears crc error flag
// RULE_15 - host clears fifos after fatal send
// RULE_16 - dma status records always, read clears
// RULE_17 - fifo empty flag is plain status bit
// RULE_18 - no fifo flush before dma interrupt
// RULE_19 - cleared enable bit masks its interrupt
// RULE_20 - fatal halts; enabled nonfatal becomes fatal; dma fatal
// RULE_21 - initiator nonfatal event set
// RULE_22 - target adds attention; halt disable governs halt
// RULE_23 - masked nonfatal: status only, no pending
// RULE_24 - stacked: line off three clocks, load, reassert
// RULE_25 - line active for enabled pending status
module sfi_irq_ctrl #(
    parameter FUNC_IS_B = 0, // 0: first function, 1: second function
    parameter DMA_BITS = 7 // interrupt-related dma status bits
) (
    input wire clk,
    input wire resetn,
    input wire memBusBit4Strap, // strap pin, pulled up routes function B to line A
    input wire [7:0] scsiEvt0, // one-cycle scsi conditions, status 0 group
    input wire [7:0] scsiEvt1, // one-cycle scsi conditions, status 1 group
    input wire [DMA_BITS-1:0] dmaEvt, // one-cycle dma conditions
    input wire onTheFlyIrqSet, // script raises on-the-fly interrupt
    input wire [7:0] scsiIrqEnable0,
    input wire [7:0] scsiIrqEnable1,
    input wire [DMA_BITS-1:0] dmaIrqEnable,
    input wire pinIrqDisable,
    input wire targetMode, // 1: target, 0: initiator
    input wire haltOnErrorDisable,
    input wire rxFromScsi, // data moving from scsi bus toward memory
    input wire dmaFifoEmpty, // live dma fifo empty level
    input wire scriptRunning,
    input wire hostAccessReq, // host slave access attempt
    input wire hostAccessStatusGroup, // attempt targets the status group
    input wire hostRdScsiStatus, // pulse: host reads both scsi status registers
    input wire hostRdDmaStatus, // pulse: host reads dma status
    input wire hostWrOnTheFlyOne, // pulse: host writes one to on-the-fly bit
    output wire hostAccessGrant,
    output wire [7:0] scsiIrqStatus0,
    output wire [7:0] scsiIrqStatus1,
    output wire [7:0] dmaStatusReg,
    output wire scsiIrqPending,
    output wire dmaIrqPending,
    output wire onTheFlyIrq,
    output wire scriptHalt, // one-cycle halt request to the script processor
    output wire dmaFifoFlushReq, // level: drain fifo before posting
    output wire crcErrorClear, // one-cycle clear of crc error flag
    output wire irqLineAOut,
    output wire irqLineAOe,
    output wire irqLineBOut,
    output wire irqLineBOe
);

    // first level status and pending flags
    reg [15:0] scsiStat_ff;
    reg [15:0] nxt_scsiStat;
    reg [DMA_BITS-1:0] dmaStat_ff;
    reg [DMA_BITS-1:0] nxt_dmaStat;
    reg sip_ff;
    reg nxt_sip;
    reg dip_ff;
    reg nxt_dip;
    reg on_the_fly_irq_ff;
    // second level stack behind the status registers
    reg [15:0] scsiStk_ff;
    reg [15:0] nxt_scsiStk;
    reg [DMA_BITS-1:0] dmaStk_ff;
    reg [DMA_BITS-1:0] nxt_dmaStk;
    // line release gap before a stacked load
    reg [1:0] gapCnt_ff;
    reg [1:0] nxt_gapCnt;
    // fatal scsi events parked while the fifo drains
    reg [15:0] scsiHold_ff;
    reg [15:0] nxt_scsiHold;
    // line drive state and misc pulses
    reg irqAct_ff;
    reg nxt_irqAct;
    reg halt_ff;
    reg nxt_halt;
    reg crcClr_ff;
    reg fifoEmpty_ff;
    // strap synchroniser and capture
    reg strapSync1_ff;
    reg strapSync2_ff;
    reg strapCap_ff;
    reg [1:0] strapCnt_ff;

    // combinational helpers
    reg [15:0] scsiEvIn;
    reg [15:0] scsiEn;
    reg [15:0] fatalMask;
    reg [15:0] haltMask;
    reg [15:0] scsiPost;
    reg stackMode;
    reg gapEnd;
    reg enabledPend;

    // classify and route incoming events
    always @* begin
        scsiEvIn = {scsiEvt1, scsiEvt0};
        scsiEn = {scsiIrqEnable1, scsiIrqEnable0};
        // nonfatal class depends on mode; enabling a nonfatal makes it fatal
        if (targetMode) begin
            fatalMask = scsiEn | ~`SFI_NONFATAL_TGT; // [RULE_22] [RULE_20]
        end else begin
            fatalMask = scsiEn | ~`SFI_NONFATAL_INIT; // [RULE_21] [RULE_20]
        end
        // attention in target mode may be kept from halting the script
        if (targetMode && haltOnErrorDisable) begin
            haltMask = fatalMask & ~`SFI_ATN_MASK; // [RULE_22]
        end else begin
            haltMask = fatalMask;
        end
        // park fatal events while receiving with data still in the fifo
        nxt_scsiHold = scsiHold_ff;
        scsiPost = scsiEvIn;
        if (scsiHold_ff != 16'h0000) begin
            if (fifoEmpty_ff) begin
                scsiPost = scsiEvIn | scsiHold_ff; // fifo drained, post now [RULE_13]
                nxt_scsiHold = 16'h0000;
            end else begin
                nxt_scsiHold = scsiHold_ff | scsiEvIn; // keep order behind the park
                scsiPost = 16'h0000;
            end
        end else if (rxFromScsi && !fifoEmpty_ff && ((scsiEvIn & fatalMask) != 16'h0000)) begin
            nxt_scsiHold = scsiEvIn; // [RULE_13]
            scsiPost = 16'h0000;
        end
        // stacking while a first level interrupt or a gap is outstanding
        stackMode = sip_ff || dip_ff || (gapCnt_ff != 2'h0);
        gapEnd = (gapCnt_ff == 2'h1);
        enabledPend = ((scsiStat_ff & scsiEn) != 16'h0000) ||
            ((dmaStat_ff & dmaIrqEnable) != {DMA_BITS{1'b0}}) || on_the_fly_irq_ff; // [RULE_19]
    end

    // next state of status, stack, pending flags and gap
    always @* begin
        nxt_scsiStat = scsiStat_ff;
        nxt_dmaStat = dmaStat_ff;
        nxt_sip = sip_ff;
        nxt_dip = dip_ff;
        nxt_scsiStk = scsiStk_ff;
        nxt_dmaStk = dmaStk_ff;
        nxt_gapCnt = gapCnt_ff;
        // reads clear the first level; set-by-event wins via the stack
        if (hostRdScsiStatus) begin
            nxt_scsiStat = 16'h0000; // [RULE_12]
            nxt_sip = 1'b0; // [RULE_12]
        end
        if (hostRdDmaStatus) begin
            nxt_dmaStat = {DMA_BITS{1'b0}}; // [RULE_16]
            nxt_dip = 1'b0; // [RULE_16]
        end
        if (stackMode) begin
            // new events wait in the second level
            nxt_scsiStk = scsiStk_ff | scsiPost;
            nxt_dmaStk = dmaStk_ff | dmaEvt;
        end else begin
            // every condition is recorded, enabled or not
            nxt_scsiStat = nxt_scsiStat | scsiPost; // [RULE_11]
            nxt_dmaStat = nxt_dmaStat | dmaEvt; // [RULE_16]
            // masked nonfatal events stay out of the pending flag
            if ((scsiPost & fatalMask) != 16'h0000) begin
                nxt_sip = 1'b1; // [RULE_06] [RULE_23]
            end
            if (dmaEvt != {DMA_BITS{1'b0}}) begin
                nxt_dip = 1'b1; // every dma event is fatal [RULE_07] [RULE_20]
            end
        end
        // stacked events and a cleared first level open the release gap
        if (gapCnt_ff != 2'h0) begin
            nxt_gapCnt = gapCnt_ff - 2'h1;
        end else if ((hostRdScsiStatus || hostRdDmaStatus) &&
            ((nxt_scsiStk != 16'h0000) || (nxt_dmaStk != {DMA_BITS{1'b0}}))) begin
            nxt_gapCnt = `SFI_GAP_LOAD; // [RULE_24]
        end
        // after the gap, move the stack into any cleared class
        if (gapEnd) begin
            if (!sip_ff) begin
                nxt_scsiStat = scsiStk_ff; // [RULE_24] [RULE_12]
                nxt_sip = (scsiStk_ff & fatalMask) != 16'h0000;
                nxt_scsiStk = scsiPost;
            end
            if (!dip_ff) begin
                nxt_dmaStat = dmaStk_ff; // [RULE_24] [RULE_16]
                nxt_dip = dmaStk_ff != {DMA_BITS{1'b0}};
                nxt_dmaStk = dmaEvt;
            end
        end
    end

    // line drive: held while asserted, blocked for new assertions
    always @* begin
        if (gapCnt_ff != 2'h0) begin
            nxt_irqAct = 1'b0; // released during the stack gap [RULE_24]
        end else if (irqAct_ff) begin
            nxt_irqAct = enabledPend; // stays until serviced [RULE_09]
        end else begin
            nxt_irqAct = enabledPend && !pinIrqDisable; // [RULE_25] [RULE_09]
        end
        // halt on any fatal event not excluded by haltMask, whether stacked or parked-then-posted
        nxt_halt = ((scsiPost & haltMask) != 16'h0000) ||
            (dmaEvt != {DMA_BITS{1'b0}}); // [RULE_20]
    end

    // main state registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scsiStat_ff <= 16'h0000;
            dmaStat_ff <= {DMA_BITS{1'b0}};
            sip_ff <= 1'b0;
            dip_ff <= 1'b0;
            scsiStk_ff <= 16'h0000;
            dmaStk_ff <= {DMA_BITS{1'b0}};
            gapCnt_ff <= 2'h0;
            scsiHold_ff <= 16'h0000;
            irqAct_ff <= 1'b0;
            halt_ff <= 1'b0;
            crcClr_ff <= 1'b0;
            fifoEmpty_ff <= 1'b1;
        end else begin
            scsiStat_ff <= nxt_scsiStat;
            dmaStat_ff <= nxt_dmaStat;
            sip_ff <= nxt_sip;
            dip_ff <= nxt_dip;
            scsiStk_ff <= nxt_scsiStk;
            dmaStk_ff <= nxt_dmaStk;
            gapCnt_ff <= nxt_gapCnt;
            scsiHold_ff <= nxt_scsiHold;
            irqAct_ff <= nxt_irqAct;
            halt_ff <= nxt_halt;
            crcClr_ff <= hostRdScsiStatus; // [RULE_14]
            // fifo empty tracks the fifo and ignores status reads
            fifoEmpty_ff <= dmaFifoEmpty; // [RULE_17]
        end
    end

    // on-the-fly flag: a set in the clear cycle wins
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            on_the_fly_irq_ff <= 1'b0;
        end else if (onTheFlyIrqSet) begin
            on_the_fly_irq_ff <= 1'b1;
        end else if (hostWrOnTheFlyOne) begin
            on_the_fly_irq_ff <= 1'b0; // only a written one clears it [RULE_04]
        end
    end

    // strap: two flops, then captured once after reset release
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strapSync1_ff <= 1'b0;
            strapSync2_ff <= 1'b0;
            strapCap_ff <= 1'b0;
            strapCnt_ff <= 2'h0;
        end else begin
            strapSync1_ff <= memBusBit4Strap;
            strapSync2_ff <= strapSync1_ff;
            // counter parks at 3 so the strap is taken only once
            if (strapCnt_ff < `SFI_STRAP_CAPTURE_CNT) begin
                strapCnt_ff <= strapCnt_ff + 2'h1;
            end else if (strapCnt_ff == `SFI_STRAP_CAPTURE_CNT) begin
                strapCap_ff <= strapSync2_ff; // [RULE_02]
                strapCnt_ff <= 2'h3;
            end
        end
    end

    // host may only reach the status group while the script runs
    assign hostAccessGrant = hostAccessReq && (!scriptRunning || hostAccessStatusGroup); // [RULE_03]

    // register views; fifo empty rides along at bit 7
    assign scsiIrqStatus0 = scsiStat_ff[7:0];
    assign scsiIrqStatus1 = scsiStat_ff[15:8];
    assign dmaStatusReg = {fifoEmpty_ff, dmaStat_ff}; // [RULE_17]
    assign scsiIrqPending = sip_ff;
    assign dmaIrqPending = dip_ff;
    assign onTheFlyIrq = on_the_fly_irq_ff;
    assign scriptHalt = halt_ff;
    // no flush request for dma events, only for parked scsi ones
    assign dmaFifoFlushReq = scsiHold_ff != 16'h0000; // [RULE_13] [RULE_18]
    assign crcErrorClear = crcClr_ff;

    // open-drain lines: drive low while enabled
    assign irqLineAOut = 1'b0;
    assign irqLineBOut = 1'b0;
    assign irqLineAOe = irqAct_ff && ((FUNC_IS_B == 0) || strapCap_ff); // [RULE_01] [RULE_02]
    assign irqLineBOe = irqAct_ff && (FUNC_IS_B != 0) && !strapCap_ff; // [RULE_02]

endmodule

// *** include/sfi_irq_defines.vh ***
// constants for the scsi function interrupt logic
`ifndef SFI_IRQ_DEFINES_VH
`define SFI_IRQ_DEFINES_VH
// scsi status bit positions inside {status_1, status_0}
`define SFI_BIT_ATN_ACTIVE 0
`define SFI_BIT_RESELECTION 5
`define SFI_BIT_CHOSEN_BY_INIT 6
`define SFI_BIT_ARB_DONE 7
`define SFI_BIT_HANDSHAKE_TMR 8
`define SFI_BIT_PURPOSE_TMR 9
// nonfatal classes per mode, 16-bit vectors over {status_1, status_0}
`define SFI_NONFATAL_INIT 16'h03E0
`define SFI_NONFATAL_TGT 16'h03E1
`define SFI_ATN_MASK 16'h0001
// dma status bit holding the fifo empty flag
`define SFI_BIT_FIFO_EMPTY 7
// line released for this many clocks before stacked status loads
`define SFI_STACK_GAP_CLKS 3
`define SFI_GAP_LOAD 2'h3
// synchroniser depth seen by the strap capture counter
`define SFI_STRAP_CAPTURE_CNT 2'h2
`endif

// *** test/sfi_irq_ctrl_properties.sv ***
// assertion checker for the scsi function interrupt logic
module sfi_irq_ctrl_props #(
    parameter FUNC_IS_B = 0,
    parameter DMA_BITS = 7
) (
    input wire clk,
    input wire resetn,
    input wire [7:0] scsiEvt0,
    input wire [7:0] scsiEvt1,
    input wire [DMA_BITS-1:0] dmaEvt,
    input wire [7:0] scsiIrqEnable0,
    input wire pinIrqDisable,
    input wire dmaFifoEmpty,
    input wire scriptRunning,
    input wire hostAccessReq,
    input wire hostAccessStatusGroup,
    input wire hostRdScsiStatus,
    input wire hostRdDmaStatus,
    input wire hostWrOnTheFlyOne,
    input wire hostAccessGrant,
    input wire [7:0] dmaStatusReg,
    input wire scsiIrqPending,
    input wire dmaIrqPending,
    input wire onTheFlyIrq,
    input wire scriptHalt,
    input wire dmaFifoFlushReq,
    input wire crcErrorClear,
    input wire irqLineAOut,
    input wire irqLineAOe,
    input wire irqLineBOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // only the status group is reachable while the script runs
    AST_GRANT: assert property (hostAccessGrant ==
        (hostAccessReq && (!scriptRunning || hostAccessStatusGroup)))
        else $error("grant wrong");
    AST_CRC_CLR: assert property (hostRdScsiStatus |=> crcErrorClear)
        else $error("crc flag not cleared");
    AST_SCSI_CLR: assert property (hostRdScsiStatus |=> !scsiIrqPending)
        else $error("scsi pending kept");
    AST_DMA_CLR: assert property (hostRdDmaStatus |=> !dmaIrqPending && dmaStatusReg[6:0] == 7'h00)
        else $error("dma status kept");
    // empty flag mirrors the fifo, reads leave it alone
    AST_FIFO_FLAG: assert property ($past(resetn) |-> dmaStatusReg[7] == $past(dmaFifoEmpty))
        else $error("fifo empty flag wrong");
    AST_OTF_HOLD: assert property (onTheFlyIrq && !hostWrOnTheFlyOne |=> onTheFlyIrq)
        else $error("on the fly flag lost");
    AST_PIN_BLOCK: assert property ($rose(irqLineAOe) |-> !$past(pinIrqDisable))
        else $error("line rose while disabled");
    AST_LINE_ROUTE: assert property (FUNC_IS_B != 0 || (!irqLineBOe && !irqLineAOut))
        else $error("function A used line B");
    // an event landing with the read is stacked, so the line must rest
    AST_STACK_GAP: assert property (hostRdScsiStatus && scsiIrqPending && scsiEvt0 != 8'h00
        && !dmaIrqPending && !onTheFlyIrq |-> ##2 !irqLineAOe [*3])
        else $error("stack gap too short");
    AST_NONFATAL: assert property (scsiEvt0 == 8'h20 && scsiEvt1 == 8'h00 && dmaEvt == 0
        && !scsiIrqEnable0[5] && !scsiIrqPending && !dmaIrqPending && !dmaFifoFlushReq
        |=> !scriptHalt && !scsiIrqPending)
        else $error("masked nonfatal halted");
    AST_DMA_FATAL: assert property (dmaEvt != 0 && !dmaIrqPending && !scsiIrqPending
        && !hostRdDmaStatus && !hostRdScsiStatus |=> scriptHalt && dmaIrqPending)
        else $error("dma event not fatal");
    COV_STACK: cover property (hostRdScsiStatus && scsiIrqPending && scsiEvt0 != 8'h00);
    COV_LINE: cover property ($rose(irqLineAOe));
    COV_PARK: cover property (dmaFifoFlushReq);
endmodule
bind sfi_irq_ctrl sfi_irq_ctrl_props #(.FUNC_IS_B(FUNC_IS_B), .DMA_BITS(DMA_BITS))
    sfi_irq_ctrl_props_i (.*);

// *** test/sfi_host_model.sv ***
// host model that services pending interrupts one access at a time
module sfi_host_model (
    input wire clk,
    input wire svcEn, // bench lets the host service
    input wire scsiIrqPending,
    input wire dmaIrqPending,
    input wire onTheFlyIrq,
    output logic rdScsi,
    output logic rdDma,
    output logic wrOtfOne
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {rdScsi, rdDma, wrOtfOne} = 3'h0;
    // one-cycle pulse, then a rest so flags settle before the next look
    always @(posedge clk) begin
        if (rdScsi || rdDma || wrOtfOne) begin // look again next cycle, a retry
            {rdScsi, rdDma, wrOtfOne} <= 3'h0;
        end else if (svcEn && onTheFlyIrq) begin
            wrOtfOne <= 1'h1;
        end else if (svcEn && scsiIrqPending) begin
            rdScsi <= 1'h1;
        end else if (svcEn && dmaIrqPending) begin
            rdDma <= 1'h1;
        end
    end
endmodule

// *** test/sfi_testbench.sv ***
// self-checking bench for the scsi function interrupt logic
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, resetn = 1'h0, otfSet = 1'h0, pinDis = 1'h0, tgt = 1'h0, hod = 1'h0;
    logic rx = 1'h0, fifoE = 1'h1, run = 1'h0, req = 1'h0, grp = 1'h0, svc = 1'h0;
    logic [7:0] e0 = 8'h00, en0 = 8'hFF, b;
    logic [6:0] de = 7'h00, den = 7'h7F;
    logic pendQ = 1'h0; // pending seen last cycle
    logic [31:0] lf = 32'hCE4391C1; // random source
    logic [22:0] q[$]; // expected {status1, status0, dma bits}
    int fails = 0, checks = 0;
    wire rdS, rdD, wrO, sp, dp, otf, halt, flush, aOe, bOe, grant, crc;
    wire [7:0] s0, s1, ds;
    sfi_irq_ctrl #(.FUNC_IS_B(0), .DMA_BITS(7)) sfi_irq_ctrl_i (
        .clk(clk), .resetn(resetn), .memBusBit4Strap(1'h0), .scsiEvt0(e0),
        .scsiEvt1(8'h00), .dmaEvt(de), .onTheFlyIrqSet(otfSet), .scsiIrqEnable0(en0),
        .scsiIrqEnable1(8'hFF), .dmaIrqEnable(den), .pinIrqDisable(pinDis), .targetMode(tgt),
        .haltOnErrorDisable(hod), .rxFromScsi(rx), .dmaFifoEmpty(fifoE), .scriptRunning(run),
        .hostAccessReq(req), .hostAccessStatusGroup(grp), .hostRdScsiStatus(rdS),
        .hostRdDmaStatus(rdD), .hostWrOnTheFlyOne(wrO), .hostAccessGrant(grant),
        .scsiIrqStatus0(s0), .scsiIrqStatus1(s1), .dmaStatusReg(ds), .scsiIrqPending(sp),
        .dmaIrqPending(dp), .onTheFlyIrq(otf), .scriptHalt(halt), .dmaFifoFlushReq(flush),
        .crcErrorClear(crc), .irqLineAOut(), .irqLineAOe(aOe), .irqLineBOut(), .irqLineBOe(bOe));
    sfi_host_model sfi_host_model_i (.clk(clk), .svcEn(svc), .scsiIrqPending(sp),
        .dmaIrqPending(dp), .onTheFlyIrq(otf), .rdScsi(rdS), .rdDma(rdD), .wrOtfOne(wrO));
    initial forever #2.5 clk = ~clk;
    function automatic logic [31:0] lfsrStep(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string n, input logic [22:0] got, input logic [22:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one-cycle event, taken at the next rising edge
    task automatic pulse(input logic [7:0] a, input logic [6:0] d);
        e0 = a;
        de = d;
        cyc(1);
        e0 = 8'h00;
        de = 7'h00;
    endtask
    // host gets two cycles for a single service access
    task automatic service();
        svc = 1'h1;
        cyc(2);
        svc = 1'h0;
    endtask
    task automatic test_done();
        if (fails == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // snapshot compared when a pending flag comes up while neither was up
    always @(negedge clk) begin
        if ((sp || dp) === 1'h1 && pendQ !== 1'h1)
            chk("status", {s1, s0, ds[6:0]}, q.size() ? q.pop_front() : 23'h7FFFFF);
        pendQ = sp || dp;
    end
    initial begin
        cyc(2);
        chk("rstDma", ds, 23'h80);
        resetn = 1'h1;
        cyc(3);
        repeat (4) begin
            lf = lfsrStep(lf);
            b = 8'h02 << lf[1:0]; // fatal class bits only
            q.push_back({8'h00, b, 7'h00});
            pulse(b, 7'h00);
            cyc(1);
            chk("lines", {aOe, bOe}, 2'h2);
            service();
            chk("cleared", {s0, sp, crc}, 10'h001);
        end
        den = 7'h00;
        q.push_back({16'h0000, 7'h01 << lf[3:2]});
        pulse(8'h00, 7'h01 << lf[3:2]);
        chk("dmaHalt", halt, 1'h1);
        cyc(1);
        chk("dmaMask", {aOe, dp}, 2'h1);
        service();
        den = 7'h7F;
        pinDis = 1'h1;
        q.push_back({8'h00, 8'h10, 7'h00});
        pulse(8'h10, 7'h00);
        cyc(2);
        chk("blocked", {aOe, sp}, 2'h1);
        pinDis = 1'h0;
        cyc(2);
        chk("unblocked", aOe, 1'h1);
        svc = 1'h1;
        cyc(1);
        svc = 1'h0;
        q.push_back({8'h00, 8'h08, 7'h00});
        pulse(8'h08, 7'h00); // lands with the read, so it stacks
        cyc(1); // line lets go one clock after the read is taken
        repeat (3) begin
            chk("gap", aOe, 1'h0);
            cyc(1);
        end
        chk("reassert", {aOe, s0}, 9'h108);
        service();
        rx = 1'h1;
        fifoE = 1'h0;
        cyc(1);
        q.push_back({8'h00, 8'h04, 7'h00});
        pulse(8'h04, 7'h00);
        cyc(1);
        chk("parked", {flush, sp}, 2'h2);
        fifoE = 1'h1; // host drains the fifo
        cyc(3);
        chk("posted", {flush, sp}, 2'h1);
        rx = 1'h0;
        service();
        for (int m = 0; m < 2; m++) begin
            tgt = m[0];
            b = m[0] ? 8'h01 : 8'h20;
            en0 = ~b;
            cyc(1);
            pulse(b, 7'h00);
            chk("nonfatal", {s0 & b, sp, halt}, {b, 2'h0});
            en0 = 8'hFF;
        end
        // enabled attention in target mode: pending, but halt held off
        hod = 1'h1;
        q.push_back({8'h00, 8'h21, 7'h00}); // earlier masked bits ride along
        pulse(8'h01, 7'h00);
        chk("noHalt", {sp, halt}, 2'h2);
        service();
        hod = 1'h0;
        otfSet = 1'h1;
        cyc(1);
        otfSet = 1'h0;
        cyc(2);
        chk("otfHold", otf, 1'h1);
        service();
        chk("otfClear", otf, 1'h0);
        run = 1'h1;
        req = 1'h1;
        for (int g = 0; g < 2; g++) begin
            grp = g[0];
            cyc(1);
            chk("grant", grant, g[0]);
        end
        chk("drained", q.size(), 23'h000000);
        test_done();
    end
    // the sequence needs about sixty cycles
    initial begin
        repeat (1000) @(posedge clk);
        fails++;
        test_done();
    end
endmodule
